/* src/ats_sector_reader.sv */
// task-file registers and the pio sector read command engine
//
// Operation
// - opcodes 20h and 21h both start the same sector read.
// - logical mode address is head bits, cylinder high, cylinder low, sector.
// - read count from sector count, zero meaning 256 sectors.
// - seek to the target track first when the head is elsewhere.
// - raise data request before any word of a sector moves, even on error.
// - on success address registers hold the last sector read.
// - an erroring sector ends the command; later sectors are not read.
// - after an error address registers hold the failing sector.
// - sector count shows untransferred sectors after error, zero on success.
// - the features value plays no part in the read.
// - unit/head: bit 6 logical mode, bit 4 drive pick, bits 3..0 head.
// - 1f7 writes opcode, reads status; 1f1 writes features, reads fault code.
`timescale 1ns/100ps
`default_nettype none
module ats_sector_reader
    import ats_pkg::*;
#(
    parameter int SPT   = DEF_SPT,
    parameter int HEADS = DEF_HEADS
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         en_in,
    input  wire logic [9:0]   tf_addr_in,
    input  wire logic         tf_wr_in,
    input  wire logic         tf_rd_in,
    input  wire logic [15:0]  tf_wdata_in,
    output var  logic [15:0]  tf_rdata_out,
    input  wire logic         irq_disable_in,
    input  wire logic         drive_id_in,
    output var  logic         irq_out,
    output var  ats_med_req_t med_req_out,
    input  wire logic         med_done_in,
    input  wire logic         med_err_in,
    input  wire logic         med_word_valid_in,
    input  wire logic [15:0]  med_word_in,
    output var  logic         med_word_ready_out
);
    ats_core_t     s;
    ats_core_t     next_s;
    ats_taskfile_t tf_stepped;
    logic [7:0]    cond;
    logic          picked;
    logic          pop;
    logic          bo_valid;
    logic [15:0]   bo_data;
    logic          wr_ok;
    logic          last_word;

    ats_fifo2 #(
        .WIDTH (16)
    ) u_buf (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .en_in         (en_in),
        .in_valid_in   (med_word_valid_in),
        .in_data_in    (med_word_in),
        .in_ready_out  (med_word_ready_out),
        .out_valid_out (bo_valid),
        .out_data_out  (bo_data),
        .out_ready_in  (pop)
    );

    ats_addr_step #(
        .SPT   (SPT),
        .HEADS (HEADS)
    ) u_step (
        .tf_in  (s.tf),
        .tf_out (tf_stepped)
    );

    // the drive bit chooses which of two chained devices answers
    assign picked = (s.tf.unit_head[UH_DRIVE_BIT] == drive_id_in);

    always_comb begin
        cond           = 8'h00;
        cond[CF_BUSY]  = s.bsy;
        cond[CF_READY] = !s.bsy;
        cond[CF_SEEKDONE] = s.track_ok;
        cond[CF_DRQ]   = s.drq;
        cond[CF_ERR]   = s.err;
    end

    // taskfile writes during a command are dropped rather than corrupting it
    assign wr_ok     = tf_wr_in && !s.bsy && !s.drq;
    assign last_word = (s.phase == PH_XFER) && pop && (s.words == WORDS_PER_SECTOR - 9'h001);

    always_comb begin
        next_s = s;
        pop    = 1'b0;

        // host reads
        if (tf_rd_in) begin
            case (tf_addr_in)
                REG_DATA: begin
                    // no word leaves the buffer until data request is up
                    pop          = s.drq && bo_valid;
                    next_s.rdata = pop ? bo_data : RST_WORD;
                end
                REG_FEATURE_IN_ERROR_OUT:    next_s.rdata = {8'h00, s.tf.fault};
                REG_SECTOR_COUNT:            next_s.rdata = {8'h00, s.tf.count};
                REG_SECTOR_INDEX:            next_s.rdata = {8'h00, s.tf.index};
                REG_CYLINDER_LOW_BYTE:       next_s.rdata = {8'h00, s.tf.cyl_lo};
                REG_CYLINDER_HIGH_BYTE:      next_s.rdata = {8'h00, s.tf.cyl_hi};
                REG_UNIT_HEAD_SELECT:        next_s.rdata = {8'h00, s.tf.unit_head};
                REG_OPCODE_IN_CONDITION_OUT: begin
                    next_s.rdata    = {8'h00, cond};
                    next_s.irq_pend = 1'b0;
                end
                default:                     next_s.rdata = RST_WORD;
            endcase
        end

        // host writes
        if (wr_ok) begin
            case (tf_addr_in)
                REG_FEATURE_IN_ERROR_OUT: next_s.tf.feature   = tf_wdata_in[7:0];
                REG_SECTOR_COUNT:         next_s.tf.count     = tf_wdata_in[7:0];
                REG_SECTOR_INDEX:         next_s.tf.index     = tf_wdata_in[7:0];
                REG_CYLINDER_LOW_BYTE:    next_s.tf.cyl_lo    = tf_wdata_in[7:0];
                REG_CYLINDER_HIGH_BYTE:   next_s.tf.cyl_hi    = tf_wdata_in[7:0];
                REG_UNIT_HEAD_SELECT:     next_s.tf.unit_head = tf_wdata_in[7:0];
                REG_OPCODE_IN_CONDITION_OUT: begin
                    if (picked) begin
                        next_s.irq_pend = 1'b0;
                        if (tf_wdata_in[7:0] == OPC_READ_RETRY ||
                            tf_wdata_in[7:0] == OPC_READ_NORETRY) begin
                            // features value is never consulted here
                            next_s.bsy      = 1'b1;
                            next_s.err      = 1'b0;
                            next_s.sec_err  = 1'b0;
                            next_s.tf.fault = FC_NONE;
                            next_s.remain   = (s.tf.count == 8'h00) ?
                                              MAX_SECTORS : {1'b0, s.tf.count};
                            next_s.phase    = PH_SEEK;
                        end else begin
                            // only the read is built in; anything else aborts
                            next_s.err      = 1'b1;
                            next_s.tf.fault = FC_ABORTED;
                            next_s.irq_pend = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end

        next_s.med.addr = sector_addr(s.tf);
        next_s.med.lba  = s.tf.unit_head[UH_LBA_BIT];

        case (s.phase)
            PH_IDLE: ;
            PH_SEEK: begin
                if (s.med.seek) begin
                    if (med_done_in) begin
                        next_s.med.seek = 1'b0;
                        next_s.track    = track_key(s.tf);
                        next_s.track_ok = 1'b1;
                    end
                end else if (s.track_ok && s.track == track_key(s.tf)) begin
                    next_s.med.read = 1'b1;
                    next_s.phase    = PH_READ;
                end else begin
                    // head elsewhere: implied seek before any read
                    next_s.med.seek = 1'b1;
                    next_s.track_ok = 1'b0;
                end
            end
            PH_READ: begin
                if (med_done_in) begin
                    next_s.med.read = 1'b0;
                    next_s.sec_err  = med_err_in;
                    next_s.words    = 9'h000;
                    // data request is raised even for a failed sector
                    next_s.drq      = 1'b1;
                    next_s.irq_pend = 1'b1;
                    next_s.bsy      = 1'b0;
                    next_s.phase    = PH_XFER;
                    if (med_err_in) begin
                        next_s.err      = 1'b1;
                        next_s.tf.fault = FC_UNCORRECTABLE;
                    end
                end
            end
            PH_XFER: begin
                if (pop) begin
                    next_s.words = s.words + 9'h001;
                end
                if (last_word) begin
                    next_s.drq = 1'b0;
                    if (s.sec_err || s.remain == 9'h001) begin
                        // address left on this sector; count shows what is left
                        next_s.phase    = PH_IDLE;
                        next_s.tf.count = 8'(s.remain - 9'h001);
                    end else begin
                        next_s.remain   = s.remain - 9'h001;
                        next_s.tf       = tf_stepped;
                        next_s.tf.count = 8'(s.remain - 9'h001);
                        next_s.bsy      = 1'b1;
                        next_s.phase    = PH_SEEK;
                    end
                end
            end
            default: next_s.phase = PH_IDLE;
        endcase

        // interrupt line only drives for the picked, enabled device
        next_s.irq = s.irq_pend && !irq_disable_in && picked;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{phase:    PH_IDLE,
                   tf:       '{feature: RST_ZERO, fault: RST_FAULT, count: RST_COUNT,
                               index: RST_INDEX, cyl_lo: RST_ZERO, cyl_hi: RST_ZERO,
                               unit_head: RST_ZERO},
                   remain:   9'h000,
                   words:    9'h000,
                   track:    20'h00000,
                   track_ok: 1'b0,
                   bsy:      1'b0,
                   drq:      1'b0,
                   err:      1'b0,
                   irq_pend: 1'b0,
                   sec_err:  1'b0,
                   med:      '0,
                   rdata:    RST_WORD,
                   irq:      1'b0};
        end else if (en_in) begin
            s <= next_s;
        end
    end

    assign tf_rdata_out = s.rdata;
    assign irq_out      = s.irq;
    assign med_req_out  = s.med;

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in || !en_in);

    sequence read_cmd_seq;
        wr_ok && picked && tf_addr_in == REG_OPCODE_IN_CONDITION_OUT &&
        (tf_wdata_in[7:0] == OPC_READ_RETRY || tf_wdata_in[7:0] == OPC_READ_NORETRY);
    endsequence

    sequence final_word_seq;
        last_word && (s.sec_err || s.remain == 9'h001);
    endsequence

    AST_READ_OPCODE: assert property (
        read_cmd_seq |=> s.bsy && s.phase == PH_SEEK ##1 s.bsy)
        else $error("read opcode did not start the command");

    AST_ZERO_MEANS_256: assert property (
        read_cmd_seq ##0 (s.tf.count == 8'h00) |=> s.remain == MAX_SECTORS)
        else $error("zero count not taken as 256 sectors");

    AST_LBA_ADDRESS: assert property (
        $rose(s.med.read) && s.med.lba |->
            s.med.addr[27:24] == s.tf.unit_head[3:0] && s.med.addr[7:0] == s.tf.index)
        else $error("logical address not formed from taskfile");

    AST_SEEK_BEFORE_READ: assert property (
        $rose(s.med.read) |-> s.track_ok && s.track == track_key(s.tf) && !s.med.seek)
        else $error("read issued off track");

    AST_DRQ_BEFORE_DATA: assert property (
        pop |-> s.drq && s.phase == PH_XFER)
        else $error("data word moved without data request");

    AST_FINAL_ADDRESS: assert property (
        final_word_seq |=> s.phase == PH_IDLE && s.tf.index == $past(s.tf.index) &&
                           s.tf.cyl_lo == $past(s.tf.cyl_lo))
        else $error("address moved past last or failing sector");

    AST_STOP_ON_ERROR: assert property (
        last_word && s.sec_err |=> (!s.med.read && !s.med.seek && !s.bsy) [*8])
        else $error("media activity after failing sector");

    AST_COUNT_LEFT: assert property (
        final_word_seq |=> s.tf.count == 8'($past(s.remain) - 9'h001))
        else $error("sector count wrong at command end");

    AST_ERR_BEFORE_RELEASE: assert property (
        $fell(s.bsy) && s.sec_err |-> s.err && s.tf.fault == FC_UNCORRECTABLE)
        else $error("busy released without error report");

    AST_IRQ_PER_SECTOR: assert property (
        $rose(s.drq) && !irq_disable_in && picked |=> irq_out)
        else $error("no interrupt for sector");

    AST_STATUS_READ: assert property (
        tf_rd_in && tf_addr_in == REG_OPCODE_IN_CONDITION_OUT |=>
            tf_rdata_out[7:0] == $past(cond))
        else $error("status read returned wrong value");

    AST_FAIL_ADDRESS: assert property (
        last_word && s.sec_err |=> sector_addr(s.tf) == $past(s.med.addr))
        else $error("address left off the failing sector");

    AST_SUCCESS_COUNT: assert property (
        last_word && !s.sec_err && s.remain == 9'h001 |=> s.tf.count == 8'h00)
        else $error("sector count not zero after success");

    AST_UNPICKED_IGNORED: assert property (
        wr_ok && !picked && tf_addr_in == REG_OPCODE_IN_CONDITION_OUT |=>
            !s.bsy && s.phase == $past(s.phase))
        else $error("opcode taken by the other device");

endmodule : ats_sector_reader
`default_nettype wire

/* src/ats_pkg.sv */
// shared constants, types and helpers for the sector read engine
package ats_pkg;

    // task-file byte addresses
    localparam logic [9:0] REG_DATA                    = 10'h1f0;
    localparam logic [9:0] REG_FEATURE_IN_ERROR_OUT    = 10'h1f1;
    localparam logic [9:0] REG_SECTOR_COUNT            = 10'h1f2;
    localparam logic [9:0] REG_SECTOR_INDEX            = 10'h1f3;
    localparam logic [9:0] REG_CYLINDER_LOW_BYTE       = 10'h1f4;
    localparam logic [9:0] REG_CYLINDER_HIGH_BYTE      = 10'h1f5;
    localparam logic [9:0] REG_UNIT_HEAD_SELECT        = 10'h1f6;
    localparam logic [9:0] REG_OPCODE_IN_CONDITION_OUT = 10'h1f7;

    localparam logic [7:0] OPC_READ_RETRY   = 8'h20;
    localparam logic [7:0] OPC_READ_NORETRY = 8'h21;

    // unit/head field positions
    localparam int UH_LBA_BIT   = 6;
    localparam int UH_DRIVE_BIT = 4;

    // condition flag positions
    localparam int CF_BUSY     = 7;
    localparam int CF_READY    = 6;
    localparam int CF_SEEKDONE = 4;
    localparam int CF_DRQ      = 3;
    localparam int CF_ERR      = 0;

    localparam logic [7:0] FC_NONE          = 8'h00;
    localparam logic [7:0] FC_UNCORRECTABLE = 8'h40;
    localparam logic [7:0] FC_ABORTED       = 8'h04;

    // values after reset
    localparam logic [7:0]  RST_FAULT = 8'h01;
    localparam logic [7:0]  RST_COUNT = 8'h01;
    localparam logic [7:0]  RST_INDEX = 8'h01;
    localparam logic [7:0]  RST_ZERO  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;

    localparam logic [8:0] WORDS_PER_SECTOR = 9'h100;
    localparam logic [8:0] MAX_SECTORS      = 9'h100;
    localparam int         DEF_SPT          = 63;
    localparam int         DEF_HEADS        = 16;

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] fault;
        logic [7:0] count;
        logic [7:0] index;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] unit_head;
    } ats_taskfile_t;

    // addr = {head or top address bits, cylinder high, cylinder low, sector}
    typedef struct packed {
        logic        seek;
        logic        read;
        logic        lba;
        logic [27:0] addr;
    } ats_med_req_t;

    typedef enum logic [1:0] {PH_IDLE, PH_SEEK, PH_READ, PH_XFER} ats_phase_t;

    typedef struct packed {
        ats_phase_t    phase;
        ats_taskfile_t tf;
        logic [8:0]    remain;
        logic [8:0]    words;
        logic [19:0]   track;
        logic          track_ok;
        logic          bsy;
        logic          drq;
        logic          err;
        logic          irq_pend;
        logic          sec_err;
        ats_med_req_t  med;
        logic [15:0]   rdata;
        logic          irq;
    } ats_core_t;

    function automatic logic [27:0] sector_addr(input ats_taskfile_t tf);
        sector_addr = {tf.unit_head[3:0], tf.cyl_hi, tf.cyl_lo, tf.index};
    endfunction : sector_addr

    function automatic logic [19:0] track_key(input ats_taskfile_t tf);
        if (tf.unit_head[UH_LBA_BIT])
            track_key = {tf.unit_head[3:0], tf.cyl_hi, tf.cyl_lo};
        else
            track_key = {4'h0, tf.cyl_hi, tf.cyl_lo};
    endfunction : track_key

endpackage : ats_pkg

/* src/ats_fifo2.sv */
// two-entry word buffer between media and host data port
`timescale 1ns/100ps
`default_nettype none
module ats_fifo2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             en_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output var  logic             in_ready_out,
    output var  logic             out_valid_out,
    output var  logic [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic [1:0]            cnt;
        logic                  rdy;
    } ats_fifo_state_t;

    ats_fifo_state_t s;
    ats_fifo_state_t next_s;
    logic            push;
    logic            pop;

    always_comb begin
        next_s = s;
        pop    = out_ready_in && (s.cnt != 2'h0);
        push   = in_valid_in && s.rdy;
        if (pop) begin
            next_s.slot[0] = s.slot[1];
        end
        if (push) begin
            if (s.cnt == 2'h0 || (s.cnt == 2'h1 && pop))
                next_s.slot[0] = in_data_in;
            else
                next_s.slot[1] = in_data_in;
        end
        next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
        // ready registered so the media side sees a clean level
        next_s.rdy = (next_s.cnt != 2'h2);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{slot: '0, cnt: 2'h0, rdy: 1'b1};
        end else if (en_in) begin
            s <= next_s;
        end
    end

    assign in_ready_out  = s.rdy;
    assign out_valid_out = (s.cnt != 2'h0);
    assign out_data_out  = s.slot[0];

endmodule : ats_fifo2
`default_nettype wire

/* src/ats_addr_step.sv */
// advances a task-file address to the following sector
`timescale 1ns/100ps
`default_nettype none
module ats_addr_step
    import ats_pkg::*;
#(
    parameter int SPT   = DEF_SPT,
    parameter int HEADS = DEF_HEADS
) (
    input  wire ats_taskfile_t tf_in,
    output var  ats_taskfile_t tf_out
);
    logic [27:0] lba_next;

    always_comb begin
        tf_out   = tf_in;
        lba_next = sector_addr(tf_in) + 28'h0000001;
        if (tf_in.unit_head[UH_LBA_BIT]) begin
            tf_out.unit_head[3:0] = lba_next[27:24];
            tf_out.cyl_hi         = lba_next[23:16];
            tf_out.cyl_lo         = lba_next[15:8];
            tf_out.index          = lba_next[7:0];
        end else if (tf_in.index >= 8'(SPT)) begin
            // sectors count from one, heads and cylinders from zero
            tf_out.index = 8'h01;
            if (tf_in.unit_head[3:0] >= 4'(HEADS - 1)) begin
                tf_out.unit_head[3:0]         = 4'h0;
                {tf_out.cyl_hi, tf_out.cyl_lo} = {tf_in.cyl_hi, tf_in.cyl_lo} + 16'h0001;
            end else begin
                tf_out.unit_head[3:0] = tf_in.unit_head[3:0] + 4'h1;
            end
        end else begin
            tf_out.index = tf_in.index + 8'h01;
        end
    end

endmodule : ats_addr_step
`default_nettype wire

/* sim/ats_media_model.sv */
// media side model: answers seeks and sector reads, then streams the sector words
`timescale 1ns/100ps
`default_nettype none
module ats_media_model
    import ats_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire ats_med_req_t req_in,
    input  wire logic         slow_in,
    input  wire logic [27:0]  fail_addr_in,
    output var  logic         done_out,
    output var  logic         err_out,
    output var  logic         valid_out,
    output var  logic [15:0]  word_out,
    input  wire logic         ready_in,
    output var  logic [27:0]  addr_out,
    output var  int           seeks_out,
    output var  int           reads_out
);
    logic [8:0] left;
    logic [7:0] dly;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
            err_out <= 1'b0;
            valid_out <= 1'b0;
            word_out <= 16'hffff;
            addr_out <= 28'h0000000;
            seeks_out <= 0;
            reads_out <= 0;
            left <= 9'h000;
            dly <= 8'h00;
        end else begin
            done_out <= 1'b0;
            err_out <= 1'b0;
            if (valid_out && ready_in) begin
                left <= left - 9'h001;
                valid_out <= (left != 9'h001);
                // a released line shows the inverse, so a stale word never passes
                word_out <= (left == 9'h001) ? ~word_out : word_out + 16'h0001;
            end
            // the request stays up one cycle after done, so done itself blocks a recount
            if ((req_in.seek || req_in.read) && !done_out && left == 9'h000) begin
                dly <= dly + 8'h01;
                if (dly == (slow_in ? 8'h28 : 8'h03)) begin
                    dly <= 8'h00;
                    done_out <= 1'b1;
                    if (req_in.read) begin
                        reads_out <= reads_out + 1;
                        addr_out <= req_in.addr;
                        err_out <= (req_in.addr == fail_addr_in);
                        left <= 9'h100;
                        valid_out <= 1'b1;
                        word_out <= req_in.addr[15:0];
                    end else begin
                        seeks_out <= seeks_out + 1;
                    end
                end
            end
        end
    end
endmodule : ats_media_model
`default_nettype wire

/* sim/tb_ats_sector_reader.sv */
// self-checking bench for the sector read engine
`timescale 1ns/100ps
`default_nettype none
module tb_ats_sector_reader
    import ats_pkg::*;
;
    localparam logic [6:0][7:0] RSTV = {8'h40, RST_ZERO, RST_ZERO, RST_ZERO, RST_INDEX,
                                        RST_COUNT, RST_FAULT};
    logic         clk_in, rst_n_in, wr, rd, irq_dis, drv_id, irq, done, err, val, rdy, slow;
    logic [9:0]   addr;
    logic [15:0]  wdata, rdata, word;
    logic [27:0]  fail, seen_addr, lba;
    logic [7:0]   st, o;
    logic [15:0]  v;
    ats_med_req_t req;
    int           seeks, reads, bad_count, n_checks, cycles, s0;
    logic [31:0]  seed;

    ats_sector_reader u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .en_in(1'b1),
        .tf_addr_in(addr), .tf_wr_in(wr), .tf_rd_in(rd), .tf_wdata_in(wdata),
        .tf_rdata_out(rdata), .irq_disable_in(irq_dis), .drive_id_in(drv_id),
        .irq_out(irq), .med_req_out(req), .med_done_in(done), .med_err_in(err),
        .med_word_valid_in(val), .med_word_in(word), .med_word_ready_out(rdy));
    ats_media_model u_media (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
        .slow_in(slow), .fail_addr_in(fail), .done_out(done), .err_out(err),
        .valid_out(val), .word_out(word), .ready_in(rdy), .addr_out(seen_addr),
        .seeks_out(seeks), .reads_out(reads));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [15:0] exp_word(input logic [27:0] b, input int s, input int i);
        return b[15:0] + 16'(s) + 16'(i);
    endfunction : exp_word
    task automatic results();
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
        n_checks++;
        if (seen !== ex) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, ex);
        end
    endtask : chk
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = {8'h00, d};
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [9:0] a);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        @(negedge clk_in);
        v = rdata;
    endtask : rd_reg
    // polls status until busy clears; on a sector with interrupts enabled the interrupt is awaited first
    task automatic wait_idle(input logic sec);
        int k;
        k = 0;
        while (sec && !irq_dis && irq !== 1'b1 && k < 3000) begin
            @(negedge clk_in);
            k++;
        end
        if (sec) chk({31'h0, irq}, {31'h0, !irq_dis});
        do rd_reg(REG_OPCODE_IN_CONDITION_OUT);
        while (v[CF_BUSY] !== 1'b0);
        st = v[7:0];
    endtask : wait_idle
    task automatic run(input logic [27:0] b, input logic [7:0] cnt, input logic [7:0] opc,
                       input logic l, input int fk, input int seek_ex);
        int total, last, r0, sk;
        logic [31:0] ex;
        total = (cnt == 8'h00) ? 256 : int'(cnt);
        last = (fk < total) ? fk : total - 1;
        fail = (fk < total) ? b + 28'(fk) : '1;
        r0 = reads;
        sk = seeks;
        wr_reg(REG_FEATURE_IN_ERROR_OUT, 8'(rnd()));
        wr_reg(REG_SECTOR_COUNT, cnt);
        wr_reg(REG_SECTOR_INDEX, b[7:0]);
        wr_reg(REG_CYLINDER_LOW_BYTE, b[15:8]);
        wr_reg(REG_CYLINDER_HIGH_BYTE, b[23:16]);
        wr_reg(REG_UNIT_HEAD_SELECT, {1'b0, l, 2'b00, b[27:24]});
        wr_reg(REG_OPCODE_IN_CONDITION_OUT, opc);
        repeat (2) @(negedge clk_in);
        for (int s = 0; s <= last; s++) begin
            wait_idle(1'b1);
            chk({30'h0, st[CF_DRQ], st[CF_ERR]}, {30'h0, 1'b1, 1'(s == fk)});
            chk({4'h0, seen_addr}, {4'h0, b + 28'(s)});
            chk({31'h0, req.lba}, {31'h0, l});
            repeat (8) @(negedge clk_in);
            chk({31'h0, rdy}, 32'h0); // host stall must back up into the media side
            for (int i = 0; i < 256; i++) begin
                rd_reg(REG_DATA);
                chk({16'h0, v}, {16'h0, exp_word(b, s, i)});
            end
        end
        wait_idle(1'b0);
        chk(32'(reads - r0), 32'(last + 1));
        if (seek_ex >= 0) chk(32'(seeks - sk), 32'(seek_ex));
        chk({24'h0, st}, (fk < total) ? 32'h51 : 32'h50);
        rd_reg(REG_SECTOR_COUNT);
        chk({24'h0, v[7:0]}, 32'(total - 1 - last));
        ex = {1'b0, l, 2'b00, b + 28'(last)};
        for (int i = 0; i < 4; i++) begin
            rd_reg(REG_SECTOR_INDEX + 10'(i));
            chk({24'h0, v[7:0]}, {24'h0, ex[8*i +: 8]});
        end
        rd_reg(REG_FEATURE_IN_ERROR_OUT);
        if (fk < total) chk({24'h0, v[7:0]}, {24'h0, FC_UNCORRECTABLE});
    endtask : run

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        {rst_n_in, wr, rd, irq_dis, drv_id, slow} = 6'h00;
        {addr, wdata} = 26'h0;
        fail = '1;
        seed = 32'd14159;
        {bad_count, n_checks, cycles} = {32'd0, 32'd0, 32'd0};
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd_reg(REG_FEATURE_IN_ERROR_OUT + 10'(i));
            chk({24'h0, v[7:0]}, {24'h0, RSTV[i]});
        end
        lba = 28'(rnd()) & 28'h7ffff7f;
        run(lba, 8'h02, OPC_READ_RETRY, 1'b1, 99, 1);
        irq_dis = 1'b1;
        run(lba + 28'h2, 8'h01, OPC_READ_NORETRY, 1'b1, 99, 0);
        irq_dis = 1'b0;
        slow = 1'b1;
        run(28'(rnd()) & 28'h7ffff7f, 8'h03, OPC_READ_RETRY, 1'b1, 1, -1);
        slow = 1'b0;
        run(28'(rnd()) & 28'h7ffff7f, 8'h00, OPC_READ_NORETRY, 1'b1, 1, -1);
        // chs pass; its read opcode also clears err so the abort check can trip
        run((28'(rnd()) & 28'h7ffff00) | 28'h5, 8'h02, OPC_READ_RETRY, 1'b0, 99, -1);
        for (int i = 0; i < 4; i++) begin
            o = 8'(rnd());
            if (o == OPC_READ_RETRY || o == OPC_READ_NORETRY) o = 8'h00;
            wr_reg(REG_OPCODE_IN_CONDITION_OUT, o);
            repeat (2) @(negedge clk_in);
            wait_idle(1'b0);
            chk({31'h0, st[CF_ERR]}, 32'h1);
            rd_reg(REG_FEATURE_IN_ERROR_OUT);
            chk({24'h0, v[7:0]}, {24'h0, FC_ABORTED});
        end
        s0 = seeks + reads;
        wr_reg(REG_UNIT_HEAD_SELECT, 8'h50);
        wr_reg(REG_OPCODE_IN_CONDITION_OUT, OPC_READ_RETRY);
        repeat (20) @(negedge clk_in);
        chk(32'(seeks + reads), 32'(s0));
        results();
    end
endmodule : tb_ats_sector_reader
`default_nettype wire
